// *** bench/res_bb_model.sv ***
// Baseband processor stand-in: drives power-hold, oscillator enable and charge gate.
// Assumes it shares clk_sys_i with the regulator logic; levels change on rising edges only.
`timescale 1ns/100ps
module res_bb_model (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    // Bench commands
    input  wire logic auto_hold_i,
    input  wire logic hold_req_i,
    input  wire logic osc_req_i,
    input  wire logic pulse_req_i,
    input  wire logic gate_req_i,
    // Regulator side
    input  wire logic key_status_i,
    input  wire logic main_reset_i,
    output logic      power_hold_o,
    output logic      osc_enable_o,
    output logic      pulse_enable_o,
    output logic      gate_o
);
    logic latched;

    // Polls the key on every edge out of main reset, as firmware would; a press latches power-hold while auto_hold_i is high
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latched        <= 1'b0;
            power_hold_o   <= 1'b0;
            osc_enable_o   <= 1'b0;
            pulse_enable_o <= 1'b0;
            gate_o         <= 1'b0;
        end else begin
            latched        <= auto_hold_i & (latched | (main_reset_i & key_status_i));
            power_hold_o   <= hold_req_i | latched;
            osc_enable_o   <= osc_req_i;
            pulse_enable_o <= pulse_req_i;
            gate_o         <= gate_req_i;
        end
    end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the regulator enable state logic.
// Assumes res_top and res_bb_model are compiled first; AXI master shares the clock.
`timescale 1ns/100ps
module tb;
    import res_pkg::*;
    logic         clk, rst_n, deep, undervoltage_lockout, chg, key_n, io_good, auto_hold, hold_req, osc_req;
    logic         pulse_req, gate_req, hold, osc_en, pulse_en, gate, core_en, mem_en, io_en, an_en;
    logic         osc_out, backup, divider, pass_gate, key_stat, chg_det, main_rst;
    logic [31:0]  awaddr, wdata, araddr, rdata;
    logic [3:0]   wstrb;
    logic         awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    res_resp_type bresp, rresp;
    int           errors, cmp_count, n;
    int           cycles = 0;
    // Row: deep, undervoltage_lockout, charger, key_n, hold, osc | main, osc out, backup, divider
    logic [9:0]   rows [13] = '{10'h2B1, 10'h182, 10'h042, 10'h0CA, 10'h0DF, 10'h042, 10'h00A,
                                10'h042, 10'h06A, 10'h07F, 10'h17F, 10'h271, 10'h042};

    res_top uut (.clk_sys_i(clk), .reset_n_i(rst_n), .deep_discharge_lockout_i(deep),
        .undervoltage_lockout_i(undervoltage_lockout), .charger_input_i(chg), .user_power_key_n_i(key_n),
        .processor_power_hold_i(hold), .osc_supply_enable_i(osc_en), .charge_pulse_enable_i(pulse_en),
        .processor_gate_in_i(gate), .io_supply_good_i(io_good), .core_supply_en_o(core_en),
        .memory_supply_en_o(mem_en), .io_supply_en_o(io_en), .analog_supply_en_o(an_en),
        .osc_supply_out_en_o(osc_out), .backup_clock_supply_en_o(backup), .divided_battery_en_o(divider),
        .pass_gate_drive_o(pass_gate), .key_status_out_o(key_stat), .charger_detect_out_o(chg_det),
        .main_reset_o(main_rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

    res_bb_model bb (.clk_sys_i(clk), .reset_n_i(rst_n), .auto_hold_i(auto_hold), .hold_req_i(hold_req),
        .osc_req_i(osc_req), .pulse_req_i(pulse_req), .gate_req_i(gate_req), .key_status_i(key_stat),
        .main_reset_i(main_rst), .power_hold_o(hold), .osc_enable_o(osc_en), .pulse_enable_o(pulse_en),
        .gate_o(gate));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Bounds any hang on a handshake that never answers
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    // ============================================================
    // Helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Readies are sampled mid-cycle; they only move on rising edges, so this is the edge value
    task axw(input logic [31:0] a, input logic [31:0] d, input res_resp_type er);
        logic aw, w, b;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            aw = awready & awvalid;
            w = wready & wvalid;
            b = bvalid;
            if (b) chk("bresp", {30'h0, er}, {30'h0, bresp});
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
    endtask

    task axr(input logic [31:0] a, input logic [31:0] ed, input res_resp_type er);
        logic ar, r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ar = arready & arvalid;
            r = rvalid;
            if (r) chk("rdata", ed, rdata);
            if (r) chk("rresp", {30'h0, er}, {30'h0, rresp});
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
        end while (!r);
        rready <= 1'b0;
    endtask

    task settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask

    task conclude;
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ============================================================
    // Sequence
    initial begin
        {rst_n, deep, undervoltage_lockout, chg, key_n, io_good, auto_hold, hold_req, osc_req} = 9'h018;
        {pulse_req, gate_req, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        chk("main_en_rst", 0, {core_en, mem_en, io_en, an_en, main_rst});
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        axw(32'h4, 32'h4, 2'h0);
        axr(32'h4, 32'h4, 2'h0);
        axw(32'h0, 32'h1, 2'h2);
        axr(32'h10, 32'h0, 2'h2);
        for (int i = 0; i < 13; i++) begin
            @(posedge clk);
            {deep, undervoltage_lockout, chg, key_n, hold_req, osc_req} <= rows[i][9:4];
            settle(8);
            chk("main_en", {4{rows[i][3]}}, {core_en, mem_en, io_en, an_en});
            chk("osc_out", rows[i][2], osc_out);
            chk("backup", rows[i][1], backup);
            chk("divider", rows[i][0], divider);
            chk("key_status", !rows[i][6], key_stat);
            chk("pass_gate", rows[i][7], pass_gate);
            chk("charger_det", rows[i][7], chg_det);
        end
        @(posedge clk);
        pulse_req <= 1'b1;
        chg <= 1'b1;
        for (int g = 1; g >= 0; g--) begin
            @(posedge clk);
            gate_req <= g[0];
            settle(8);
            chk("pass_gate_pulse", g, pass_gate);
        end
        @(posedge clk);
        pulse_req <= 1'b0;
        chg <= 1'b0;
        settle(10);
        @(posedge clk);
        auto_hold <= 1'b1;
        key_n <= 1'b0;
        n = 0;
        while (main_rst !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        // Three edges to turn on, then delay 4 plus one, seen at the following falling edge
        chk("reset_delay", 9, n);
        // Key stays down until power-hold has reached the logic, as firmware would ensure
        settle(6);
        chk("hold_raised", 1, hold);
        @(posedge clk);
        key_n <= 1'b1;
        settle(10);
        chk("hold_keeps_on", 1, core_en);
        chk("key_released", 0, key_stat);
        @(posedge clk);
        io_good <= 1'b0;
        settle(4);
        chk("reset_io_lost", 0, main_rst);
        chk("io_lost_still_on", 1, core_en);
        @(posedge clk);
        auto_hold <= 1'b0;
        settle(10);
        chk("shutdown", 0, {core_en, main_rst});
        @(posedge clk);
        io_good <= 1'b1;
        wstrb <= 4'h2;
        axw(32'h4, 32'h0000AB99, 2'h0);
        axr(32'h4, 32'h0000AB04, 2'h0);
        @(posedge clk);
        chg <= 1'b1;
        settle(8);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk("main_en_midrst", 0, {core_en, mem_en, io_en, an_en, backup, main_rst});
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        axr(32'h4, 32'h3E8, 2'h0);
        settle(6);
        chk("charger_after_rst", 15, {core_en, mem_en, io_en, an_en});
        conclude();
    end
endmodule

// *** common/res_defines.svh ***
// Constants for the regulator enable state logic: register map, field sizes and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef RES_DEFINES_SVH
`define RES_DEFINES_SVH

// ============================================================
// Register map (byte addresses, AXI4-Lite, 32-bit words)
`define RES_DEC_MSB         7
`define RES_ADDR_STATUS     8'h00
`define RES_ADDR_RST_DELAY  8'h04

// ============================================================
// Field sizes and reset values
`define RES_DELAY_W         16
`define RES_DELAY_PAD       16
`define RES_RST_DELAY_DEF   16'h03E8
`define RES_STATUS_PAD      16
`define RES_SYNC_W          9
`define RES_SYNC_RST        9'h009

// ============================================================
// Synchroniser bit positions
`define RES_IN_DEEP         0
`define RES_IN_UNDERVOLTAGE_LOCKOUT         1
`define RES_IN_CHG          2
`define RES_IN_KEY_N        3
`define RES_IN_HOLD         4
`define RES_IN_OSC_EN       5
`define RES_IN_PULSE_EN     6
`define RES_IN_GATE         7
`define RES_IN_IO_GOOD      8

// ============================================================
// AXI responses
`define RES_RESP_OKAY       2'h0
`define RES_RESP_SLVERR     2'h2

`endif

// *** common/res_pkg.sv ***
// Types shared by the regulator enable state logic.
// Assumes the defines header is compiled alongside.
package res_pkg;
    typedef enum logic [1:0] {
        RES_OFF_LOCKED,
        RES_OFF,
        RES_ON
    } res_state_type;

    typedef logic [1:0] res_resp_type;
endpackage

// *** verilog/res_delay_timer.sv ***
// Reset delay counter: done rises limit+1 edges after run goes high.
// Assumes run is synchronous to clk_sys_i; dropping run clears the count.
`timescale 1ns/100ps
`include "res_defines.svh"
module res_delay_timer (
    // Clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_n_i,
    // Control
    input  wire logic                    run_i,
    input  wire logic [`RES_DELAY_W-1:0] limit_i,
    output logic                         done_o
);
    logic [`RES_DELAY_W-1:0] count;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count  <= '0;
            done_o <= 1'b0;
        end else if (!run_i) begin
            count  <= '0;
            done_o <= 1'b0;
        end else if (count == limit_i) begin
            done_o <= 1'b1;
        end else begin
            count  <= count + 1'b1;
        end
    end
endmodule

// *** verilog/res_sync.sv ***
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no bits are related to each other.
`timescale 1ns/100ps
module res_sync #(
    parameter int                WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// *** verilog/res_top.sv ***
// Regulator enable state logic: decides which supplies are on from lockouts, charger, key and
// processor controls, times the main reset, and offers status and delay over AXI4-Lite.
// Assumes all control inputs are asynchronous levels and the AXI master shares clk_sys_i.
`timescale 1ns/100ps
`include "res_defines.svh"
module res_top (
    // Clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      reset_n_i,
    // Lockout and charger detectors
    input  wire logic                      deep_discharge_lockout_i,
    input  wire logic                      undervoltage_lockout_i,
    input  wire logic                      charger_input_i,
    // Key, processor controls and IO supply good
    input  wire logic                      user_power_key_n_i,
    input  wire logic                      processor_power_hold_i,
    input  wire logic                      osc_supply_enable_i,
    input  wire logic                      charge_pulse_enable_i,
    input  wire logic                      processor_gate_in_i,
    input  wire logic                      io_supply_good_i,
    // Supply enables
    output logic                           core_supply_en_o,
    output logic                           memory_supply_en_o,
    output logic                           io_supply_en_o,
    output logic                           analog_supply_en_o,
    output logic                           osc_supply_out_en_o,
    output logic                           backup_clock_supply_en_o,
    output logic                           divided_battery_en_o,
    // Processor-facing outputs
    output logic                           pass_gate_drive_o,
    output logic                           key_status_out_o,
    output logic                           charger_detect_out_o,
    output logic                           main_reset_o,
    // AXI4-Lite write address
    input  wire logic [31:0]               s_axi_awaddr_i,
    input  wire logic                      s_axi_awvalid_i,
    output logic                           s_axi_awready_o,
    // AXI4-Lite write data
    input  wire logic [31:0]               s_axi_wdata_i,
    input  wire logic [3:0]                s_axi_wstrb_i,
    input  wire logic                      s_axi_wvalid_i,
    output logic                           s_axi_wready_o,
    // AXI4-Lite write response
    output res_pkg::res_resp_type          s_axi_bresp_o,
    output logic                           s_axi_bvalid_o,
    input  wire logic                      s_axi_bready_i,
    // AXI4-Lite read address
    input  wire logic [31:0]               s_axi_araddr_i,
    input  wire logic                      s_axi_arvalid_i,
    output logic                           s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0]                    s_axi_rdata_o,
    output res_pkg::res_resp_type          s_axi_rresp_o,
    output logic                           s_axi_rvalid_o,
    input  wire logic                      s_axi_rready_i
);
    import res_pkg::*;

    // ============================================================
    // Reset release and input synchronisers
    logic                    rst_meta;
    logic                    rst_n;
    logic [`RES_SYNC_W-1:0]  raw_in;
    logic [`RES_SYNC_W-1:0]  sync_in;
    logic                    deep_s;
    logic                    undervoltage_lockout_s;
    logic                    chg_s;
    logic                    key_n_s;
    logic                    hold_s;
    logic                    osc_en_s;
    logic                    pulse_en_s;
    logic                    gate_s;
    logic                    io_good_s;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_comb begin
        raw_in                   = '0;
        raw_in[`RES_IN_DEEP]     = deep_discharge_lockout_i;
        raw_in[`RES_IN_UNDERVOLTAGE_LOCKOUT]     = undervoltage_lockout_i;
        raw_in[`RES_IN_CHG]      = charger_input_i;
        raw_in[`RES_IN_KEY_N]    = user_power_key_n_i;
        raw_in[`RES_IN_HOLD]     = processor_power_hold_i;
        raw_in[`RES_IN_OSC_EN]   = osc_supply_enable_i;
        raw_in[`RES_IN_PULSE_EN] = charge_pulse_enable_i;
        raw_in[`RES_IN_GATE]     = processor_gate_in_i;
        raw_in[`RES_IN_IO_GOOD]  = io_supply_good_i;
    end

    // Deep-discharge lockout resets to in force so nothing turns on before real levels arrive
    res_sync #(
        .WIDTH   (`RES_SYNC_W),
        .RST_VAL (`RES_SYNC_RST)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .async_i   (raw_in),
        .sync_o    (sync_in)
    );

    assign deep_s     = sync_in[`RES_IN_DEEP];
    assign undervoltage_lockout_s     = sync_in[`RES_IN_UNDERVOLTAGE_LOCKOUT];
    assign chg_s      = sync_in[`RES_IN_CHG];
    assign key_n_s    = sync_in[`RES_IN_KEY_N];
    assign hold_s     = sync_in[`RES_IN_HOLD];
    assign osc_en_s   = sync_in[`RES_IN_OSC_EN];
    assign pulse_en_s = sync_in[`RES_IN_PULSE_EN];
    assign gate_s     = sync_in[`RES_IN_GATE];
    assign io_good_s  = sync_in[`RES_IN_IO_GOOD];

    // ============================================================
    // Power state decode
    res_state_type state;
    res_state_type next_state;
    logic          next_main_on;

    always_comb begin
        case (state)
            RES_OFF_LOCKED,
            RES_OFF,
            RES_ON: begin
                if (deep_s) begin
                    next_state = RES_OFF_LOCKED;
                end else if (state != RES_ON && undervoltage_lockout_s) begin
                    next_state = RES_OFF;
                end else if (chg_s || !key_n_s || hold_s) begin
                    next_state = RES_ON;
                end else begin
                    next_state = RES_OFF;
                end
            end
            default: begin
                next_state = RES_OFF_LOCKED;
            end
        endcase
    end

    assign next_main_on = (next_state == RES_ON);

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= RES_OFF_LOCKED;
        end else begin
            state <= next_state;
        end
    end

    // ============================================================
    // Supply enables
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            core_supply_en_o         <= 1'b0;
            memory_supply_en_o       <= 1'b0;
            io_supply_en_o           <= 1'b0;
            analog_supply_en_o       <= 1'b0;
            osc_supply_out_en_o      <= 1'b0;
            backup_clock_supply_en_o <= 1'b0;
        end else begin
            core_supply_en_o         <= next_main_on;
            memory_supply_en_o       <= next_main_on;
            io_supply_en_o           <= next_main_on;
            analog_supply_en_o       <= next_main_on;
            osc_supply_out_en_o      <= next_main_on && osc_en_s;
            backup_clock_supply_en_o <= !deep_s;
        end
    end

    // ============================================================
    // Processor-facing pins
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            divided_battery_en_o <= 1'b0;
            pass_gate_drive_o    <= 1'b0;
            key_status_out_o     <= 1'b0;
            charger_detect_out_o <= 1'b0;
        end else begin
            divided_battery_en_o <= osc_en_s;
            // Without pulse charging the gate follows charger presence
            pass_gate_drive_o    <= pulse_en_s ? gate_s : chg_s;
            key_status_out_o     <= !key_n_s;
            charger_detect_out_o <= chg_s;
        end
    end

    // ============================================================
    // Main reset delay
    logic [`RES_DELAY_W-1:0] rst_delay;
    logic                    timer_run;

    // Timer restarts whenever the IO supply falls out of regulation
    assign timer_run = io_good_s && (state == RES_ON);

    res_delay_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .run_i     (timer_run),
        .limit_i   (rst_delay),
        .done_o    (main_reset_o)
    );

    // ============================================================
    // AXI4-Lite slave
    logic                    aw_held;
    logic [`RES_DEC_MSB:0]   aw_addr;
    logic                    w_held;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    wr_fire;
    logic [31:0]             status_word;

    assign s_axi_awready_o = !aw_held;
    assign s_axi_wready_o  = !w_held;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign wr_fire         = aw_held && w_held && !s_axi_bvalid_o;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid_i && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i[`RES_DEC_MSB:0];
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid_i && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rst_delay <= `RES_RST_DELAY_DEF;
        end else if (wr_fire && aw_addr == `RES_ADDR_RST_DELAY) begin
            if (w_strb[0]) begin
                rst_delay[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                rst_delay[15:8] <= w_data[15:8];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `RES_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            // Status is read-only, so only the delay word accepts writes
            s_axi_bresp_o  <= (aw_addr == `RES_ADDR_RST_DELAY) ? `RES_RESP_OKAY : `RES_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    assign status_word = {{`RES_STATUS_PAD{1'b0}}, io_good_s, hold_s, !key_n_s, chg_s, undervoltage_lockout_s, deep_s,
                          main_reset_o, divided_battery_en_o, osc_supply_out_en_o, core_supply_en_o,
                          backup_clock_supply_en_o, pass_gate_drive_o, osc_en_s, pulse_en_s, state};

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= `RES_RESP_OKAY;
        end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
            s_axi_rvalid_o <= 1'b1;
            case (s_axi_araddr_i[`RES_DEC_MSB:0])
                `RES_ADDR_STATUS: begin
                    s_axi_rdata_o <= status_word;
                    s_axi_rresp_o <= `RES_RESP_OKAY;
                end
                `RES_ADDR_RST_DELAY: begin
                    s_axi_rdata_o <= {{`RES_DELAY_PAD{1'b0}}, rst_delay};
                    s_axi_rresp_o <= `RES_RESP_OKAY;
                end
                default: begin
                    s_axi_rdata_o <= '0;
                    s_axi_rresp_o <= `RES_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ============================================================
    // Checks
    a_deep_lockout_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        deep_s |=> !core_supply_en_o && !memory_supply_en_o && !io_supply_en_o && !analog_supply_en_o
                   && !osc_supply_out_en_o && !backup_clock_supply_en_o)
        else $error("supply on during deep lockout");

    a_charger_turn_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !deep_s && !undervoltage_lockout_s && chg_s |=> core_supply_en_o && memory_supply_en_o && io_supply_en_o
                                       && analog_supply_en_o && (osc_supply_out_en_o == $past(osc_en_s)))
        else $error("charger did not turn supplies on");

    a_key_turn_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !deep_s && !undervoltage_lockout_s && !key_n_s |=> core_supply_en_o && analog_supply_en_o
                                          && (osc_supply_out_en_o == $past(osc_en_s)))
        else $error("key did not turn supplies on");

    a_hold_keeps_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        core_supply_en_o && !deep_s && hold_s && !osc_en_s |=> core_supply_en_o && io_supply_en_o
                                                              && !osc_supply_out_en_o)
        else $error("power-hold did not keep supplies on");

    a_all_on_bb: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (!deep_s && (core_supply_en_o || !undervoltage_lockout_s) && hold_s && osc_en_s) [*2] |=>
            osc_supply_out_en_o && memory_supply_en_o && core_supply_en_o)
        else $error("not every supply on with hold and osc enable");

    a_undervoltage_lockout_ignored_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        core_supply_en_o && undervoltage_lockout_s && !deep_s && hold_s |=> core_supply_en_o)
        else $error("undervoltage turned a running phone off");

    a_undervoltage_lockout_blocks_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !core_supply_en_o && undervoltage_lockout_s |=> !core_supply_en_o)
        else $error("turn-on despite undervoltage while off");

    a_divider_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        $changed(osc_en_s) |=> divided_battery_en_o == $past(osc_en_s))
        else $error("divider enable not following osc enable");

    a_gate_passthru: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        pulse_en_s ##1 pulse_en_s |-> pass_gate_drive_o == $past(gate_s))
        else $error("gate drive not following processor gate");

    a_key_status: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !key_n_s |=> key_status_out_o)
        else $error("key press not shown on key status");

    a_reset_needs_io: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !timer_run |=> !main_reset_o)
        else $error("main reset high without IO regulation");

    a_reset_after_delay: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        $rose(main_reset_o) |-> $past(timer_run) && $past(timer_run, 2) || rst_delay == '0)
        else $error("main reset rose before the delay ran");
endmodule
